// File: core/ccmp_pkg.sv
/*
  Constants and carrier types of the connector moisture protection controller.
  Assumes a 20 MHz clock and comparator levels that arrive from the analog front end asynchronously.
*/
// Functional notes
// [R1] under lockout: shutdown, clamps on, rest off
// [R2] supply lockout releases the moisture flag
// [R3] leaving lockout enters active, switches closed
// [R4] vbus loss delay then wait state by sys compare
// [R5] wait_sink: switches open, probe source on
// [R6] wait_sink exits to source, active or moisture
// [R7] both lines above high: dry, flag released
// [R8] wait_source: switches open, pull-down on
// [R9] wait_source exits to sink or active
// [R10] moisture state pulls flag low, switches open
// [R11] detection enters active, probes off, switches closed
// [R12] switches open 2.5 s after vbus loss
// [R13] protect enable low: stay active, switches closed
// [R14] probe or pull-down mirrors controller after delay
// [R15] source detect: debounce, close, late pull-down release
// [R16] drop below high: probe, then sink debounce
// [R17] still above low: extend, pull-down, dead battery
// [R18] rise above high while probing: water, flag
// [R19] sea water: probes off, pull-down, switch open
// [R20] overvoltage opens the channel switch quickly
// [R21] overvoltage recovery after clean debounce period
// [R22] flag is open drain, only pulled or released
// [R23] low, high and overvoltage comparators are used
// [R24] system side compare picks pull-down or probe
// [R25] flag held in wait_source and active
// [R26] inputs synchronised, delays counted in cycles
// [R27] per channel overvoltage overrides every state
package ccmp_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  localparam int VBUS_LOSS_DELAY_MS = 2500;
  localparam int DETECT_DEBOUNCE_US = 10000;
  localparam int PROBE_WAIT_US = 1000;
  localparam int MIRROR_DELAY_US = 10;
  localparam int RD_RELEASE_US = 1000;
  localparam int OVP_RECOVER_US = 1000;

  localparam int VBUS_LOSS_CYC = VBUS_LOSS_DELAY_MS * (CLK_HZ / 1000);
  localparam int DETECT_DEBOUNCE_CYC = DETECT_DEBOUNCE_US * CYC_PER_US;
  localparam int PROBE_WAIT_CYC = PROBE_WAIT_US * CYC_PER_US;
  localparam int MIRROR_DELAY_CYC = MIRROR_DELAY_US * CYC_PER_US;
  localparam int RD_RELEASE_CYC = RD_RELEASE_US * CYC_PER_US;
  localparam int OVP_RECOVER_CYC = OVP_RECOVER_US * CYC_PER_US;
  // probe needs one cycle to reach the pin and two to pass the synchroniser
  localparam int SETTLE_CYC = 3;

  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic CTRL_PROTECT_RESET = 1'b1;
  localparam int CTRL_PROTECT_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FLAG_BIT = 16;
  localparam int STAT_SWITCH_LSB = 18;
  localparam int STAT_OVP_LSB = 20;
  localparam int STAT_PROTECT_BIT = 24;

  typedef enum logic [10:0] {
    ST_SHUT     = 11'h001,
    ST_ACTIVE   = 11'h002,
    ST_WAIT_SOURCE = 11'h004,
    ST_SRC_DEB  = 11'h008,
    ST_WAIT_SINK = 11'h010,
    ST_PROBE    = 11'h020,
    ST_SNK_DEB  = 11'h040,
    ST_PROBE_EXT = 11'h080,
    ST_PULLDN   = 11'h100,
    ST_MOIST    = 11'h200,
    ST_SPARE    = 11'h400
  } ccmp_state_e;

  typedef struct packed {
    logic supply_ok;
    logic protect_enable;
    logic vbus;
    logic [1:0] sys_side_level_cmp_out;
    logic [1:0] conn_low_cmp_out;
    logic [1:0] conn_high_cmp_out;
    logic [1:0] overvoltage_cmp_out;
  } ccmp_cmp_s;

  typedef struct packed {
    logic [1:0] switch_close;
    logic [1:0] probe_src_en;
    logic [1:0] pulldown_en;
    logic clamp_en;
    logic bias_en;
  } ccmp_drive_s;

  localparam ccmp_drive_s DRIVE_RESET = '{2'h0, 2'h0, 2'h0, 1'b1, 1'b0};

endpackage

// File: core/ccmp_protect_fsm.sv
/*
  Connector moisture and overvoltage protection controller with an Avalon-MM register slave.
  Assumes comparator outputs are asynchronous levels and that the flag pin has an external pull-up.
*/
`timescale 1ns/1ns
module ccmp_protect_fsm #(
  parameter int VBUS_N = ccmp_pkg::VBUS_LOSS_CYC,
  parameter int DEB_N = ccmp_pkg::DETECT_DEBOUNCE_CYC,
  parameter int PROBE_N = ccmp_pkg::PROBE_WAIT_CYC,
  parameter int MIRROR_N = ccmp_pkg::MIRROR_DELAY_CYC,
  parameter int RD_N = ccmp_pkg::RD_RELEASE_CYC,
  parameter int REC_N = ccmp_pkg::OVP_RECOVER_CYC
) (
  input logic clock,
  input logic rst_n,
  input ccmp_pkg::ccmp_cmp_s cmp_in,
  output ccmp_pkg::ccmp_drive_s drive,
  output logic moisture_flag_n_o,
  output logic moisture_flag_n_oe,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ccmp_pkg::*;

  if (VBUS_N < 1 || DEB_N < 1 || PROBE_N < 1 || MIRROR_N < 1 || RD_N < 1 || REC_N < 1) begin : g_bad
    $error("ccmp_protect_fsm: every cycle count must be at least one");
  end

  // two-stage synchroniser, stage one read only by stage two
  ccmp_cmp_s s_q1;
  ccmp_cmp_s s;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q1 <= '0;
      s <= '0;
    end else begin
      s_q1 <= cmp_in; // [R26]
      s <= s_q1;
    end
  end

  ccmp_state_e st;
  ccmp_state_e next_st;
  logic ctrl_protect;
  logic sys_m;
  logic lo_q;
  logic flag_oe;
  logic next_flag;
  logic [31:0] tmr;
  logic [31:0] vcnt;
  logic [31:0] mcnt;
  logic [31:0] rdh;
  logic [31:0] rcnt [2];
  logic [1:0] ovp_trip;

  // aggregated connector view: both lines above high, any line above low
  wire hi = &s.conn_high_cmp_out; // [R23]
  wire lo = |s.conn_low_cmp_out; // [R23]
  wire sys_any = |s.sys_side_level_cmp_out;
  wire pe = s.protect_enable & ctrl_protect;
  wire vbus_lost = !s.vbus && vcnt == 32'(VBUS_N - 1);
  wire deb_done = tmr == 32'(DEB_N - 1);
  wire probe_done = tmr == 32'(PROBE_N - 1);
  // a fresh wait_sink still sees the line as it was before its probe came on
  wire settled = tmr >= 32'(SETTLE_CYC);
  wire tmr_clr = next_st != st || (st == ST_PULLDN && lo != lo_q);

  always_comb begin
    next_st = st;
    if (!s.supply_ok) begin
      next_st = ST_SHUT; // [R1]
    end else if (!pe) begin
      next_st = ST_ACTIVE; // [R13]
    end else begin
      unique case (st)
        ST_SHUT: next_st = ST_ACTIVE; // [R3]
        ST_ACTIVE: begin
          if (vbus_lost) begin
            next_st = sys_m ? ST_WAIT_SINK : ST_WAIT_SOURCE; // [R4] [R12]
          end
        end
        ST_WAIT_SOURCE: begin
          if (sys_m) begin
            next_st = ST_WAIT_SINK; // [R9]
          end else if (lo) begin
            next_st = ST_SRC_DEB; // [R9] [R15]
          end
        end
        ST_SRC_DEB: begin
          if (!lo) begin
            next_st = ST_WAIT_SOURCE;
          end else if (deb_done) begin
            next_st = ST_ACTIVE; // [R15] [R11]
          end
        end
        ST_WAIT_SINK: begin
          if (!sys_m) begin
            next_st = ST_WAIT_SOURCE; // [R6]
          end else if (!hi && settled) begin
            next_st = ST_PROBE; // [R6] [R16]
          end
        end
        ST_PROBE: begin
          if (hi) begin
            next_st = ST_MOIST; // [R18]
          end else if (probe_done) begin
            next_st = lo ? ST_PROBE_EXT : ST_SNK_DEB; // [R16] [R17]
          end
        end
        ST_SNK_DEB: begin
          if (hi) begin
            next_st = ST_MOIST; // [R18]
          end else if (lo) begin
            next_st = ST_WAIT_SINK;
          end else if (deb_done) begin
            next_st = ST_ACTIVE; // [R16] [R11]
          end
        end
        ST_PROBE_EXT: begin
          if (hi) begin
            next_st = ST_MOIST; // [R18]
          end else if (deb_done) begin
            next_st = ST_PULLDN; // [R17] [R19]
          end
        end
        ST_PULLDN: begin
          // timer restarts on every low-compare change, so either verdict is debounced
          if (deb_done) begin
            next_st = lo ? ST_MOIST : ST_ACTIVE; // [R17] [R19] [R6]
          end
        end
        ST_MOIST: next_st = sys_m ? ST_WAIT_SINK : ST_WAIT_SOURCE; // [R10]
        default: next_st = ST_SHUT;
      endcase
    end
  end

  // flag changes only in shutdown, moisture or dry detection
  always_comb begin
    next_flag = flag_oe; // [R25]
    if (!s.supply_ok || st == ST_SHUT) begin
      next_flag = 1'b0; // [R2]
    end else if (st == ST_MOIST) begin
      next_flag = 1'b1; // [R10]
    end else if (st == ST_WAIT_SINK && hi && settled) begin
      next_flag = 1'b0; // [R7]
    end
  end

  // drive decode from the current state
  wire in_probe = st == ST_WAIT_SINK || st == ST_PROBE || st == ST_SNK_DEB || st == ST_PROBE_EXT || st == ST_MOIST;
  wire in_pull = st == ST_WAIT_SOURCE || st == ST_SRC_DEB || st == ST_PULLDN || (st == ST_ACTIVE && rdh != 32'h0);
  wire sw_want = st == ST_ACTIVE;
  wire [1:0] sw_ok = ~(s.overvoltage_cmp_out | ovp_trip);
  ccmp_drive_s next_drive;
  assign next_drive.switch_close = sw_want ? sw_ok : 2'h0; // [R11] [R20] [R27]
  assign next_drive.probe_src_en = in_probe ? 2'h3 : 2'h0; // [R5] [R14] [R24]
  assign next_drive.pulldown_en = in_pull ? 2'h3 : 2'h0; // [R8] [R14] [R24] [R19]
  assign next_drive.clamp_en = st == ST_SHUT; // [R1]
  assign next_drive.bias_en = st != ST_SHUT; // [R1]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_SHUT;
      drive <= DRIVE_RESET;
      flag_oe <= 1'b0;
      moisture_flag_n_oe <= 1'b0;
      moisture_flag_n_o <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      st <= next_st;
      drive <= next_drive;
      flag_oe <= next_flag;
      moisture_flag_n_oe <= next_flag; // [R22]
      moisture_flag_n_o <= 1'b0; // [R22]
      lo_q <= lo;
    end
  end

  // state timer and vbus absence counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr <= 32'h0;
      vcnt <= 32'h0;
    end else begin
      tmr <= tmr_clr ? 32'h0 : tmr + 32'h1; // [R26]
      vcnt <= (st == ST_ACTIVE && pe && !s.vbus) ? vcnt + 32'h1 : 32'h0; // [R12]
    end
  end

  // mirror of the controller termination, delayed to ride out its own switching
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_m <= 1'b0;
      mcnt <= 32'h0;
    end else if (sys_any == sys_m) begin
      mcnt <= 32'h0;
    end else if (mcnt == 32'(MIRROR_N - 1)) begin
      sys_m <= sys_any; // [R14]
      mcnt <= 32'h0;
    end else begin
      mcnt <= mcnt + 32'h1;
    end
  end

  // pull-down kept after a source closes the switch, so it never sees an open line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdh <= 32'h0;
    end else if (st == ST_SRC_DEB && next_st == ST_ACTIVE) begin
      rdh <= 32'(RD_N); // [R15]
    end else if (rdh != 32'h0) begin
      rdh <= rdh - 32'h1;
    end
  end

  // per-channel trip; the synchroniser adds two cycles to the opening time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ovp_trip <= 2'h0;
      rcnt[0] <= 32'h0;
      rcnt[1] <= 32'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (s.overvoltage_cmp_out[i]) begin
          ovp_trip[i] <= 1'b1; // [R20] [R27]
          rcnt[i] <= 32'h0;
        end else if (ovp_trip[i] && rcnt[i] == 32'(REC_N - 1)) begin
          ovp_trip[i] <= 1'b0; // [R21]
          rcnt[i] <= 32'h0;
        end else if (ovp_trip[i]) begin
          rcnt[i] <= rcnt[i] + 32'h1;
        end
      end
    end
  end

  // Avalon slave: every access waits exactly one cycle
  wire req = avs_read | avs_write;
  wire commit_wr = avs_write && !avs_waitrequest;
  wire ctrl_hit = avs_address == CTRL_OFS;
  wire stat_hit = avs_address == STAT_OFS;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  always_comb begin
    stat_word = 32'h0;
    stat_word[STAT_STATE_LSB +: 11] = st;
    stat_word[STAT_FLAG_BIT] = flag_oe;
    stat_word[STAT_SWITCH_LSB +: 2] = drive.switch_close;
    stat_word[STAT_OVP_LSB +: 2] = ovp_trip;
    stat_word[STAT_PROTECT_BIT] = pe;
    rd_mux = 32'h0;
    if (ctrl_hit) begin
      rd_mux[CTRL_PROTECT_BIT] = ctrl_protect;
    end else if (stat_hit) begin
      rd_mux = stat_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_protect <= CTRL_PROTECT_RESET;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      if (commit_wr && ctrl_hit && avs_byteenable[0]) begin
        ctrl_protect <= avs_writedata[CTRL_PROTECT_BIT];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_shutdown_drive: assert property (st == ST_SHUT |=> // [R1]
    drive.switch_close == 2'h0 && drive.clamp_en && !drive.bias_en && drive.probe_src_en == 2'h0)
    else $error("shutdown drive wrong");

  a_flag_lockout: assert property (!s.supply_ok |=> !moisture_flag_n_oe) // [R2]
    else $error("flag not released in lockout");

  a_wake_active: assert property (st == ST_SHUT && s.supply_ok |=> st == ST_ACTIVE ##1 // [R3]
    drive.switch_close == $past(sw_ok))
    else $error("no wake to active");

  a_vbus_timeout: assert property (st == ST_ACTIVE && s.supply_ok && pe && vbus_lost |=> // [R4]
    (st == ST_WAIT_SINK || st == ST_WAIT_SOURCE) ##1 drive.switch_close == 2'h0)
    else $error("vbus loss exit wrong");

  a_vbus_early: assert property (st == ST_ACTIVE && vcnt < 32'(VBUS_N - 1) && s.supply_ok |=> // [R12]
    st == ST_ACTIVE)
    else $error("left active before vbus delay");

  a_sink_drive: assert property (st == ST_WAIT_SINK |=> // [R5]
    drive.probe_src_en == 2'h3 && drive.switch_close == 2'h0 && drive.pulldown_en == 2'h0)
    else $error("wait_sink drive wrong");

  a_sink_to_src: assert property (st == ST_WAIT_SINK && s.supply_ok && pe && !sys_m |=> // [R6]
    st == ST_WAIT_SOURCE)
    else $error("wait_sink did not follow controller");

  a_dry_release: assert property (st == ST_WAIT_SINK && s.supply_ok && hi && settled |=> !flag_oe ##1 // [R7]
    !moisture_flag_n_oe)
    else $error("dry did not release flag");

  a_src_drive: assert property (st == ST_WAIT_SOURCE |=> // [R8]
    drive.pulldown_en == 2'h3 && drive.switch_close == 2'h0 && drive.probe_src_en == 2'h0)
    else $error("wait_source drive wrong");

  a_moist_flag: assert property (st == ST_MOIST && s.supply_ok |=> flag_oe && // [R10]
    (st == ST_WAIT_SINK || st == ST_WAIT_SOURCE || !pe))
    else $error("moisture did not pull flag");

  a_flag_hold: assert property ((st == ST_ACTIVE || st == ST_WAIT_SOURCE) && s.supply_ok |=> // [R25]
    $stable(flag_oe))
    else $error("flag moved while held");

  a_disable_active: assert property (s.supply_ok && !pe |=> st == ST_ACTIVE) // [R13]
    else $error("protect off did not force active");

  a_ovp_open: assert property (s.overvoltage_cmp_out[0] |=> !drive.switch_close[0] // [R20]
    && ovp_trip[0])
    else $error("overvoltage did not open switch");

  a_ovp_hold: assert property ($fell(s.overvoltage_cmp_out[1]) |-> ovp_trip[1] && // [R21]
    !next_drive.switch_close[1])
    else $error("recovery too early");

  a_rd_release: assert property (st == ST_SRC_DEB && next_st == ST_ACTIVE |=> // [R15]
    rdh == 32'(RD_N) ##1 drive.pulldown_en == 2'h3)
    else $error("pull-down released early");

  a_settle_wait: assert property (st == ST_WAIT_SINK && !settled && s.supply_ok && pe && sys_m |=> // [R6]
    st == ST_WAIT_SINK)
    else $error("wait_sink left before probe settled");

  a_src_detect: assert property (st == ST_WAIT_SOURCE && s.supply_ok && pe && !sys_m && lo |=> // [R9]
    st == ST_SRC_DEB)
    else $error("source not picked up");

  a_sea_drive: assert property (st == ST_PULLDN |=> // [R19]
    drive.probe_src_en == 2'h0 && drive.pulldown_en == 2'h3 && drive.switch_close == 2'h0)
    else $error("pull-down phase drive wrong");

  a_moist_open: assert property (st == ST_MOIST |=> // [R10]
    drive.switch_close == 2'h0)
    else $error("switch closed in moisture");

  a_ovp_open_two: assert property (s.overvoltage_cmp_out[1] |=> !drive.switch_close[1] // [R27]
    && ovp_trip[1])
    else $error("second channel did not open");

  a_sink_close: assert property (st == ST_SNK_DEB && next_st == ST_ACTIVE |-> // [R11]
    ##2 drive.switch_close == $past(sw_ok) && drive.probe_src_en == 2'h0)
    else $error("sink not connected");

  a_mirror_hold: assert property (sys_any != sys_m && mcnt != 32'(MIRROR_N - 1) |=> // [R14]
    $stable(sys_m))
    else $error("mirror followed too early");

  c_water: cover property (st == ST_PROBE ##1 st == ST_MOIST);
  c_source: cover property (st == ST_SRC_DEB ##1 st == ST_ACTIVE);
  c_sink: cover property (st == ST_SNK_DEB ##1 st == ST_ACTIVE);
  c_dead_batt: cover property (st == ST_PULLDN ##1 st == ST_ACTIVE);
  c_ovp: cover property ($fell(ovp_trip[0]));

endmodule

// File: testbench/ccmp_cc_partner.sv
/*
  Far-side model: the system-side controller termination and one connector accessory.
  Assumes the protection controller's drive outputs are the only feedback it sees.
*/
`timescale 1ns/1ns
module ccmp_cc_partner
  import ccmp_pkg::*;
(
  input logic clock,
  input logic rst_n,
  input ccmp_pkg::ccmp_drive_s drive,
  input logic ctl_pullup,
  input logic [2:0] acc,
  output logic [1:0] sys_cmp,
  output logic [1:0] low_cmp,
  output logic [1:0] high_cmp
);
  logic [4:0] chg_cnt;
  logic [2:0] acc_q;
  // water charges up only while probe current flows; the count restarts on any change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chg_cnt <= 5'h00;
      acc_q <= 3'h0;
    end else begin
      acc_q <= acc;
      if (acc != acc_q || drive.probe_src_en == 2'h0)
        chg_cnt <= 5'h00;
      else if (chg_cnt != 5'h1F)
        chg_cnt <= chg_cnt + 5'h01;
    end
  end
  // controller sources pull-up current when high, terminates low otherwise
  assign sys_cmp = {2{ctl_pullup}};
  // acc: 0 open, 1 source, 2 sink, 3 dead battery, 4 tap water, 5 sea water
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (acc)
        3'h1: begin low_cmp[i] = 1'b1; high_cmp[i] = 1'b0; end
        3'h2: begin low_cmp[i] = 1'b0; high_cmp[i] = 1'b0; end
        3'h3: begin low_cmp[i] = drive.probe_src_en[i]; high_cmp[i] = 1'b0; end
        // tap water rises above high only for a while, then sags: no free dry reading
        3'h4: begin low_cmp[i] = 1'b1; high_cmp[i] = chg_cnt >= 5'h08 && chg_cnt < 5'h0C; end
        3'h5: begin low_cmp[i] = 1'b1; high_cmp[i] = 1'b0; end
        default: begin low_cmp[i] = drive.probe_src_en[i]; high_cmp[i] = drive.probe_src_en[i]; end
      endcase
    end
  end
endmodule

// File: testbench/ccmp_protect_fsm_test.sv
/*
  Self-checking bench for the protection controller with shortened delay parameters.
  Assumes the partner model for the connector side and an external pull-up on the flag.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module ccmp_protect_fsm_test;
  import ccmp_pkg::*;
  logic clock, rst_n, supply_ok, protect_en, vbus, ctl_pullup;
  logic [2:0] acc;
  logic [1:0] ov, sys_cmp, low_cmp, high_cmp;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest, flag_o, flag_oe;
  logic [31:0] avs_writedata, avs_readdata, rd;
  ccmp_cmp_s cmp_in;
  ccmp_drive_s drive;
  int tests_run, mismatches, cyc;
  wire flag_n = flag_oe ? flag_o : 1'b1; // host pull-up, device only pulls low
  assign cmp_in = '{supply_ok, protect_en, vbus, sys_cmp, low_cmp, high_cmp, ov};
  ccmp_protect_fsm #(.VBUS_N(20), .DEB_N(8), .PROBE_N(6), .MIRROR_N(3), .RD_N(5), .REC_N(4))
  ccmp_protect_fsm_inst (.clock(clock), .rst_n(rst_n), .cmp_in(cmp_in), .drive(drive),
    .moisture_flag_n_o(flag_o), .moisture_flag_n_oe(flag_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ccmp_cc_partner ccmp_cc_partner_inst (.clock(clock), .rst_n(rst_n), .drive(drive), .ctl_pullup(ctl_pullup),
    .acc(acc), .sys_cmp(sys_cmp), .low_cmp(low_cmp), .high_cmp(high_cmp));
  always #25 clock = ~clock;
  task results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ceiling well above the fewer than two thousand cycles the scenarios need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      results();
    end
  end
  // request held until waitrequest is sampled low, released right after
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  function logic [1:0] pick(input int sel);
    case (sel)
      0: return drive.switch_close;
      1: return drive.probe_src_en;
      2: return drive.pulldown_en;
      default: return {1'b0, flag_n};
    endcase
  endfunction
  task wait_for(input int sel, input logic [1:0] v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge clock);
      if (pick(sel) === v)
        break;
    end
  endtask
  task wait_st(input logic [10:0] st, input int lim);
    for (int k = 0; k < lim; k++) begin
      bus(1'b0, STAT_OFS, 32'h0);
      if (rd[10:0] === st)
        break;
    end
  endtask
  task goto_wait(input logic pull);
    ctl_pullup <= pull;
    acc <= 3'h0;
    wait_st(pull ? ST_WAIT_SINK : ST_WAIT_SOURCE, 40);
  endtask
  task t_reset;
    `CHK("reset drive", DRIVE_RESET, drive)
    `CHK("reset flag", 1'b1, flag_n)
    rst_n <= 1'b1;
    wait_st(ST_ACTIVE, 5);
    `CHK("state", ST_ACTIVE, rd[10:0])
    `CHK("switch", 2'h3, drive.switch_close)
  endtask
  task t_regs;
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", CTRL_PROTECT_RESET, rd[CTRL_PROTECT_BIT])
    bus(1'b0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, CTRL_OFS, 32'h0);
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK("protect off", 1'b0, rd[STAT_PROTECT_BIT])
    avs_byteenable <= 4'hE;
    bus(1'b1, CTRL_OFS, 32'h1);
    avs_byteenable <= 4'hF;
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK("masked write", 1'b0, rd[CTRL_PROTECT_BIT])
    bus(1'b1, CTRL_OFS, 32'h1);
  endtask
  task t_vbus;
    vbus <= 1'b0;
    repeat (15) @(posedge clock);
    `CHK("switch held", 2'h3, drive.switch_close)
    wait_for(0, 2'h0, 30);
    `CHK("switch open", 2'h0, drive.switch_close)
    wait_st(ST_WAIT_SINK, 5);
    `CHK("state", ST_WAIT_SINK, rd[10:0])
    `CHK("probe", 2'h3, drive.probe_src_en)
  endtask
  task t_sink;
    goto_wait(1'b1);
    acc <= 3'h2;
    wait_for(0, 2'h3, 60);
    `CHK("sink close", 2'h3, drive.switch_close)
    `CHK("probe off", 2'h0, drive.probe_src_en)
  endtask
  task t_src;
    goto_wait(1'b0);
    `CHK("pulldown", 2'h3, drive.pulldown_en)
    `CHK("probe", 2'h0, drive.probe_src_en)
    ctl_pullup <= 1'b1;
    wait_st(ST_WAIT_SINK, 10);
    `CHK("to sink", ST_WAIT_SINK, rd[10:0])
    ctl_pullup <= 1'b0;
    wait_st(ST_WAIT_SOURCE, 10);
    `CHK("to source", ST_WAIT_SOURCE, rd[10:0])
    acc <= 3'h1;
    wait_for(0, 2'h3, 40);
    `CHK("src close", 2'h3, drive.switch_close)
    `CHK("pd kept", 2'h3, drive.pulldown_en)
    wait_for(2, 2'h0, 20);
    `CHK("pd released", 2'h0, drive.pulldown_en)
  endtask
  task t_dead;
    goto_wait(1'b1);
    acc <= 3'h3;
    wait_for(0, 2'h3, 80);
    `CHK("dead close", 2'h3, drive.switch_close)
  endtask
  task t_water;
    goto_wait(1'b1);
    wait_for(3, 2'h1, 40);
    `CHK("dry first", 1'b1, flag_n)
    acc <= 3'h4;
    wait_for(3, 2'h0, 80);
    `CHK("flag low", 1'b0, flag_n)
    `CHK("switch", 2'h0, drive.switch_close)
  endtask
  task t_dry;
    acc <= 3'h0;
    wait_for(3, 2'h1, 200);
    `CHK("dry flag", 1'b1, flag_n)
  endtask
  task t_sea;
    goto_wait(1'b1);
    acc <= 3'h5;
    wait_for(2, 2'h3, 80);
    `CHK("sea pd", 2'h3, drive.pulldown_en)
    `CHK("sea open", 2'h0, drive.switch_close)
    `CHK("sea probe", 2'h0, drive.probe_src_en)
  endtask
  task t_supply;
    supply_ok <= 1'b0;
    wait_for(3, 2'h1, 10);
    `CHK("uvlo flag", 1'b1, flag_n)
    wait_st(ST_SHUT, 5);
    `CHK("shut drive", DRIVE_RESET, drive)
    supply_ok <= 1'b1;
    acc <= 3'h0;
    wait_st(ST_ACTIVE, 10);
    `CHK("back active", 2'h3, drive.switch_close)
  endtask
  task t_ovp;
    protect_en <= 1'b0; // host picks plain switch mode
    wait_st(ST_ACTIVE, 40);
    repeat (40) @(posedge clock);
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK("stay active", ST_ACTIVE, rd[10:0])
    ov <= 2'h1;
    repeat (5) @(posedge clock);
    `CHK("ovp open", 2'h2, drive.switch_close)
    ov <= 2'h0;
    repeat (2) @(posedge clock);
    `CHK("ovp held", 2'h2, drive.switch_close)
    wait_for(0, 2'h3, 20);
    `CHK("ovp recover", 2'h3, drive.switch_close)
    ov <= 2'h2;
    repeat (5) @(posedge clock);
    `CHK("ovp open two", 2'h1, drive.switch_close)
    ov <= 2'h0;
    wait_for(0, 2'h3, 20);
    `CHK("ovp recover two", 2'h3, drive.switch_close)
    protect_en <= 1'b1;
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    supply_ok = 1'b1;
    protect_en = 1'b1;
    vbus = 1'b1;
    ctl_pullup = 1'b1;
    acc = 3'h0;
    ov = 2'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    tests_run = 0;
    mismatches = 0;
    cyc = 0;
    repeat (8) @(posedge clock);
    t_reset();
    t_regs();
    t_vbus();
    t_sink();
    t_src();
    t_dead();
    t_water();
    t_dry();
    t_sea();
    t_water();
    t_supply();
    t_ovp();
    results();
  end
endmodule
